// file: verilog/serial_unit_pkg.sv
// Constants and types shared by the universal serial shift unit.
// Assumes a single 40 MHz system clock; all times become cycle counts here.
`default_nettype none
package serial_unit_pkg;

  // Wire modes: outputs off, three-wire, two-wire, two-wire with ovf hold
  typedef enum logic [1:0] {
    WM_OFF      = 2'b00,
    WM_THREE    = 2'b01,
    WM_TWO      = 2'b10,
    WM_TWO_HOLD = 2'b11
  } wire_mode_type;

  // System clock period and derived timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SDA_DELAY_NS  = 100;
  localparam int SDA_DLY_CYC   =
    (SDA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_DIV       = 4;
  localparam int TOGGLE_GAP    = SCL_DIV / 2;

  // Status write field positions
  localparam int ST_START_BIT = 7;
  localparam int ST_OVF_BIT   = 6;
  localparam int ST_STOP_BIT  = 5;
  localparam int ST_CNT_MSB   = 3;

  // Reset and limit values
  localparam logic [3:0] CNT_MAX    = 4'hF;
  localparam logic [3:0] CNT_RESET  = 4'h0;
  localparam logic [3:0] CNT_ONE    = 4'h1;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [1:0] GAP_LOAD   = 2'(TOGGLE_GAP - 1);
  localparam logic [1:0] GAP_ZERO   = 2'h0;
  localparam logic [1:0] GAP_ONE    = 2'h1;
  localparam logic [1:0] BUF_DEPTH  = 2'h2;
  localparam logic [1:0] BUF_EMPTY  = 2'h0;
  localparam logic [1:0] BUF_ONE    = 2'h1;

  // Either two-wire encoding
  function automatic logic is_two_wire(input logic [1:0] mode);
    is_two_wire = (mode == WM_TWO) || (mode == WM_TWO_HOLD);
  endfunction : is_two_wire

endpackage : serial_unit_pkg
`default_nettype wire

// file: verilog/universal_serial_shift_unit.sv
// Universal serial shift unit: 8-bit shift register, 4-bit edge counter,
// two-wire start/stop detection with clock hold, three-wire shifting.
// Assumes pins arrive asynchronously and are resolved by the bench from
// the output enables; control writes are one-cycle strobes on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module universal_serial_shift_unit
  import serial_unit_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Control write strobe and fields
  input  wire logic       ctrl_wr,
  input  wire logic [1:0] wire_mode,
  input  wire logic       clock_source_select_hi,
  input  wire logic       clock_edge_select,
  input  wire logic       shift_clock_strobe,
  input  wire logic       clock_pin_toggle_strobe,
  // Status write and status view
  input  wire logic       status_wr,
  input  wire logic [7:0] status_wdata,
  output logic            start_detect_flag,
  output logic            counter_overflow_flag,
  output logic            stop_flag,
  output logic            collision,
  output logic [3:0]      edge_count,
  // Shift data access
  input  wire logic       data_wr,
  input  wire logic [7:0] data_wdata,
  output logic [7:0]      shift_data_register,
  // Timer compare match event
  input  wire logic       timer_match,
  // Pin drive enables
  input  wire logic       clock_out_en,
  input  wire logic       data_out_en,
  // Serial clock pin
  input  wire logic       serial_clock_pin_i,
  output logic            serial_clock_pin_o,
  output logic            serial_clock_pin_oe,
  // Data in pin, also two-wire data line
  input  wire logic       data_in_pin_i,
  output logic            data_in_pin_o,
  output logic            data_in_pin_oe,
  // Data out pin
  output logic            data_out_pin_o,
  output logic            data_out_pin_oe,
  // Clockless start hint
  output logic            start_wake,
  // Received byte stream
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data
);

  logic [2:0]             scl_sync_q;
  logic [2:0]             sda_sync_q;
  logic                   scl_lvl_q;
  logic                   sda_lvl_q;
  logic                   scl_new;
  logic                   sda_new;
  logic                   scl_rise;
  logic                   scl_fall;
  logic [SDA_DLY_CYC-1:0] sda_dly_q;
  logic                   two_wire;
  logic                   start_det;
  logic                   stop_det;
  logic                   sample_edge;
  logic                   change_edge;
  logic                   soft_strobe;
  logic                   shift_ev;
  logic                   tog_sel;
  logic                   count_ev;
  logic                   toggle_take;
  logic                   wrap;
  logic [1:0]             gap_q;
  logic                   cnt_tog_q;
  logic [7:0]             shift_q;
  logic [7:0]             shift_d;
  logic                   out_bit_q;
  logic [3:0]             cnt_q;
  logic                   ovf_q;
  logic                   start_q;
  logic                   start_hold_q;
  logic                   stop_q;
  logic                   coll_q;
  logic                   scl_drive_q;
  logic                   scl_hold;
  logic [7:0]             buf_mem_q [0:1];
  logic                   buf_wp_q;
  logic                   buf_rp_q;
  logic [1:0]             buf_cnt_q;
  logic                   buf_in_ready;
  logic                   push;
  logic                   pop;

  // Three-stage pin synchronisers; only the second stage reads the first
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], serial_clock_pin_i};
      sda_sync_q <= {sda_sync_q[1:0], data_in_pin_i};
    end
  end

  // A level change counts once stages two and three agree
  assign scl_new  = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2]
                                                     : scl_lvl_q;
  assign sda_new  = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2]
                                                     : sda_lvl_q;
  assign scl_rise = scl_new & ~scl_lvl_q;
  assign scl_fall = ~scl_new & scl_lvl_q;

  // Filtered levels; the bus idles high, so reset to one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_lvl_q <= 1'b1;
      sda_lvl_q <= 1'b1;
    end else begin
      scl_lvl_q <= scl_new;
      sda_lvl_q <= sda_new;
    end
  end

  // Data delay line so clock is settled when data moves
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sda_dly_q <= '1;
    end else begin
      sda_dly_q <= {sda_dly_q[SDA_DLY_CYC-2:0], sda_lvl_q};
    end
  end

  // Start/stop decode, only in two-wire modes
  assign two_wire  = is_two_wire(wire_mode);
  assign start_det = two_wire & scl_lvl_q & sda_dly_q[SDA_DLY_CYC-1]
                   & ~sda_dly_q[SDA_DLY_CYC-2];
  assign stop_det  = two_wire & scl_lvl_q & ~sda_dly_q[SDA_DLY_CYC-1]
                   & sda_dly_q[SDA_DLY_CYC-2];

  // Clockless wake hint; software qualifies it with the start flag
  assign start_wake = two_wire & serial_clock_pin_i
                    & ~data_in_pin_i;

  // Clock source selection and edge choice
  assign sample_edge = clock_source_select_hi
                     & (clock_edge_select ? scl_fall : scl_rise);
  assign change_edge = clock_source_select_hi
                     & (clock_edge_select ? scl_rise : scl_fall);
  assign soft_strobe = ctrl_wr & shift_clock_strobe
                     & ~clock_source_select_hi;
  assign shift_ev    = clock_source_select_hi ? sample_edge
                     : (clock_edge_select ? timer_match
                                          : soft_strobe);
  assign toggle_take = ctrl_wr & clock_pin_toggle_strobe
                     & (gap_q == GAP_ZERO);
  assign tog_sel     = ctrl_wr ? shift_clock_strobe : cnt_tog_q;
  assign count_ev    = clock_source_select_hi
                     ? (tog_sel ? toggle_take
                                : (scl_rise | scl_fall))
                     : shift_ev;
  assign wrap        = count_ev & ~status_wr
                     & (cnt_q == CNT_MAX);

  // Toggle spacing keeps the driven clock at a quarter of clk_sys at most
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap_q <= GAP_ZERO;
    end else if (toggle_take) begin
      gap_q <= GAP_LOAD;
    end else if (gap_q != GAP_ZERO) begin
      gap_q <= gap_q - GAP_ONE;
    end
  end

  // Counter-from-toggle option remembered from the last control write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_tog_q <= 1'b0;
    end else if (ctrl_wr) begin
      cnt_tog_q <= shift_clock_strobe & clock_source_select_hi;
    end
  end

  // Driven serial clock level, toggled by the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_drive_q <= 1'b1;
    end else if (toggle_take) begin
      scl_drive_q <= ~scl_drive_q;
    end
  end

  // Shift register; a write in the same cycle beats the shift
  assign shift_d = data_wr ? data_wdata
                 : (shift_ev ? {shift_q[6:0], sda_lvl_q}
                             : shift_q);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_q <= DATA_RESET;
    end else begin
      shift_q <= shift_d;
    end
  end

  // Output latch: open with internal clock and through the change half
  // of an external clock, so a freshly written MSB shows before the
  // first sample edge; closed from the sample edge to the change edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_bit_q <= 1'b1;
    end else if (~clock_source_select_hi | change_edge
                 | (clock_edge_select ? scl_lvl_q & scl_new
                                      : ~scl_lvl_q & ~scl_new)) begin
      out_bit_q <= shift_q[7];
    end
  end

  // Edge counter; a status write loads it and wins over counting
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= CNT_RESET;
    end else if (status_wr) begin
      cnt_q <= status_wdata[ST_CNT_MSB:0];
    end else if (count_ev) begin
      cnt_q <= cnt_q + CNT_ONE;
    end
  end

  // Overflow flag: a same-cycle status write suppresses the set, so the clear applies
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovf_q <= 1'b0;
    end else if (wrap) begin
      ovf_q <= 1'b1;
    end else if (status_wr & status_wdata[ST_OVF_BIT]) begin
      ovf_q <= 1'b0;
    end
  end

  // Start flag, cleared by writing one; a new start wins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_q <= 1'b0;
    end else if (start_det) begin
      start_q <= 1'b1;
    end else if (status_wr & status_wdata[ST_START_BIT]) begin
      start_q <= 1'b0;
    end
  end

  // Start hold engages on the first clock fall after a start
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_hold_q <= 1'b0;
    end else if (~two_wire) begin
      start_hold_q <= 1'b0;
    end else if (status_wr & status_wdata[ST_START_BIT] & ~start_det) begin
      start_hold_q <= 1'b0;
    end else if ((start_q | start_det) & scl_fall) begin
      start_hold_q <= 1'b1;
    end
  end

  // Stop flag and data collision
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stop_q <= 1'b0;
      coll_q <= 1'b0;
    end else begin
      coll_q <= two_wire & (out_bit_q != sda_lvl_q);
      if (stop_det) begin
        stop_q <= 1'b1;
      end else if (status_wr & status_wdata[ST_STOP_BIT]) begin
        stop_q <= 1'b0;
      end
    end
  end

  // Slave clock stretch: start hold, overflow hold, or full buffer
  assign scl_hold = two_wire & (start_hold_q
                  | ((wire_mode == WM_TWO_HOLD) & ovf_q)
                  | ~buf_in_ready);

  // Pin drivers; two-wire pins are open drain, so only pull low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      serial_clock_pin_o  <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
      data_in_pin_o       <= 1'b0;
      data_in_pin_oe      <= 1'b0;
      data_out_pin_o      <= 1'b0;
      data_out_pin_oe     <= 1'b0;
    end else if (two_wire) begin
      serial_clock_pin_o  <= 1'b0;
      serial_clock_pin_oe <= scl_hold
                           | (clock_out_en & ~scl_drive_q);
      data_in_pin_o       <= 1'b0;
      data_in_pin_oe      <= data_out_en & ~out_bit_q;
      data_out_pin_o      <= 1'b0;
      data_out_pin_oe     <= 1'b0;
    end else begin
      serial_clock_pin_o  <= scl_drive_q;
      serial_clock_pin_oe <= (wire_mode == WM_THREE) & clock_out_en;
      data_in_pin_o       <= 1'b0;
      data_in_pin_oe      <= 1'b0;
      data_out_pin_o      <= out_bit_q;
      data_out_pin_oe     <= (wire_mode == WM_THREE) & data_out_en;
    end
  end

  // Two-entry receive buffer; when full it stretches a two-wire clock,
  // three-wire masters must drain it before the next byte completes
  assign buf_in_ready = (buf_cnt_q != BUF_DEPTH);
  assign push         = wrap & buf_in_ready;
  assign pop          = rx_valid & rx_ready;
  assign rx_valid     = (buf_cnt_q != BUF_EMPTY);
  assign rx_data      = buf_mem_q[buf_rp_q];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      buf_mem_q[0] <= DATA_RESET;
      buf_mem_q[1] <= DATA_RESET;
      buf_wp_q     <= 1'b0;
    end else if (push) begin
      buf_mem_q[buf_wp_q] <= shift_d;
      buf_wp_q            <= ~buf_wp_q;
    end
  end

  // Read pointer and fill count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      buf_rp_q  <= 1'b0;
      buf_cnt_q <= BUF_EMPTY;
    end else begin
      if (pop) begin
        buf_rp_q <= ~buf_rp_q;
      end
      if (push & ~pop) begin
        buf_cnt_q <= buf_cnt_q + BUF_ONE;
      end else if (pop & ~push) begin
        buf_cnt_q <= buf_cnt_q - BUF_ONE;
      end
    end
  end

  // Status view
  assign start_detect_flag     = start_q;
  assign counter_overflow_flag = ovf_q;
  assign stop_flag             = stop_q;
  assign collision             = coll_q;
  assign edge_count            = cnt_q;
  assign shift_data_register   = shift_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_ovf_on_wrap: assert property (
    count_ev && !status_wr && cnt_q == CNT_MAX
      |=> counter_overflow_flag && edge_count == CNT_RESET)
    else $error("overflow flag not set on counter wrap");

  a_soft_strobe_count: assert property (
    soft_strobe && !status_wr |=> edge_count == $past(cnt_q) + CNT_ONE)
    else $error("software strobe did not advance counter");

  a_start_sets_flag: assert property (
    start_det |=> start_detect_flag)
    else $error("start condition did not set flag");

  a_start_mode_gate: assert property (
    !two_wire |-> !start_det)
    else $error("start detected outside two-wire mode");

  a_start_clear: assert property (
    status_wr && status_wdata[ST_START_BIT] && !start_det
      |=> !start_detect_flag && !start_hold_q)
    else $error("start flag clear did not release hold");

  a_start_hold_pin: assert property (
    two_wire && start_hold_q && $stable(wire_mode)
      |=> serial_clock_pin_oe && !serial_clock_pin_o)
    else $error("start hold not driving clock low");

  a_ovf_hold_pin: assert property (
    wire_mode == WM_TWO_HOLD && ovf_q && $stable(wire_mode)
      |=> serial_clock_pin_oe)
    else $error("overflow hold not driving clock low");

  a_toggle_rate: assert property (
    toggle_take |=> !toggle_take)
    else $error("clock toggled faster than quarter rate");

  a_toggle_counts: assert property (
    ctrl_wr && clock_source_select_hi && shift_clock_strobe
      && toggle_take && !status_wr
      |=> scl_drive_q != $past(scl_drive_q)
          && edge_count == $past(cnt_q) + CNT_ONE)
    else $error("toggle strobe did not toggle and count");

  a_rise_shift: assert property (
    clock_source_select_hi && !clock_edge_select && scl_rise && !data_wr
      |=> shift_data_register == {$past(shift_q[6:0]), $past(sda_lvl_q)})
    else $error("data not shifted in on clock rise");

endmodule : universal_serial_shift_unit
`default_nettype wire

// file: tb/serial_far_end.sv
// Far-side model: three-wire master or slave, two-wire bus master.
// Assumes the bench merges its drives into wired-AND lines with a pull-up.
`timescale 1ns/100ps
`default_nettype none
module serial_far_end (
  // Resolved lines as the far side sees them
  input  wire logic clk_seen,
  input  wire logic data_seen,
  input  wire logic miso,
  // Far-side drives, high means released on the open-drain lines
  output logic      clk_drv,
  output logic      data_drv
);
  logic       mclk     = 1'b1;
  logic       mdata    = 1'b1;
  logic       slave_en = 1'b0;
  logic [7:0] tx_q     = 8'h00;
  logic [7:0] rx_q     = 8'h00;

  // Clock only moves inside frames; idle level set by the bench
  assign clk_drv  = mclk;
  assign data_drv = slave_en ? tx_q[7] : mdata;

  // Slave: capture on rise, next bit on fall, refill with a moving pattern
  always @(posedge clk_seen) if (slave_en) rx_q <= {rx_q[6:0], miso};
  always @(negedge clk_seen) if (slave_en) tx_q <= {tx_q[6:0], ~tx_q[0]};

  // Master byte in clock mode 0; sample late so the unit's lag is covered
  task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mdata = tx[i];
      #100 mclk = 1'b1;
      #95 rx = {rx[6:0], miso};
      #5 mclk = 1'b0;
    end
    #100 mdata = ~mdata;
  endtask : spi_xfer

  // Release the clock and wait, bounded, while a slave stretches it
  task automatic release_clk();
    mclk = 1'b1;
    for (int n = 0; n < 400 && !clk_seen; n++) #25;
  endtask : release_clk

  // Data falls while the clock is high, then the clock is pulled low
  task automatic i2c_start();
    mdata = 1'b0;
    #300 mclk = 1'b0;
    #300;
  endtask : i2c_start

  // Data changes only while the clock is low
  task automatic i2c_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      mdata = v[i];
      #100 release_clk();
      #100 mclk = 1'b0;
      #100;
    end
  endtask : i2c_byte

  // Acknowledge slot: line released, slave is expected to pull it low
  task automatic i2c_ack(output logic b);
    mdata = 1'b1;
    #100 release_clk();
    #50 b = data_seen;
    #50 mclk = 1'b0;
    #100;
  endtask : i2c_ack

  // Data rises while the clock is high
  task automatic i2c_stop();
    mdata = 1'b0;
    #100 release_clk();
    #200 mdata = 1'b1;
    #300;
  endtask : i2c_stop
endmodule : serial_far_end
`default_nettype wire

// file: tb/universal_serial_shift_unit_tb.sv
// Bench for the serial shift unit: counter sources, receive buffer,
// three-wire master and slave, two-wire start, hold and receive.
// Assumes the far-side model shares the open-drain lines by wired-AND.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
  end \
end
module universal_serial_shift_unit_tb;
  // Clock, reset and tallies
  logic       clk_sys = 1'b0;
  logic       rst     = 1'b1;
  int         num_errors = 0;
  int         n_tests    = 0;
  // Unit inputs
  logic       ctrl_wr = 1'b0, shift_clock_strobe = 1'b0;
  logic       clock_source_select_hi = 1'b0, clock_edge_select = 1'b0;
  logic       clock_pin_toggle_strobe = 1'b0, status_wr = 1'b0;
  logic       data_wr = 1'b0, timer_match = 1'b0, rx_ready = 1'b0;
  logic       clock_out_en = 1'b0, data_out_en = 1'b0;
  logic [1:0] wire_mode = 2'b00;
  logic [7:0] status_wdata = 8'h00, data_wdata = 8'h00;
  // Unit outputs
  logic       start_detect_flag, counter_overflow_flag, rx_valid;
  logic       stop_flag, collision, start_wake;
  logic       serial_clock_pin_o, serial_clock_pin_oe, data_in_pin_o;
  logic       data_in_pin_oe, data_out_pin_o, data_out_pin_oe;
  logic [3:0] edge_count;
  logic [7:0] shift_data_register, rx_data, got;
  // Resolved lines
  wire logic  far_clk, far_dat, scl_w, sda_w, miso_w, held;

  // Wired-AND with pull-up; an undriven data out line keeps moving
  assign scl_w  = (serial_clock_pin_oe ? serial_clock_pin_o : 1'b1)
                  & far_clk;
  assign sda_w  = (data_in_pin_oe ? data_in_pin_o : 1'b1) & far_dat;
  assign miso_w = data_out_pin_oe ? data_out_pin_o : clk_sys;
  assign held   = serial_clock_pin_oe & ~serial_clock_pin_o;

  universal_serial_shift_unit universal_serial_shift_unit_i (
    .clk_sys, .rst, .ctrl_wr, .wire_mode, .clock_source_select_hi,
    .clock_edge_select, .shift_clock_strobe, .clock_pin_toggle_strobe,
    .status_wr, .status_wdata, .start_detect_flag, .counter_overflow_flag,
    .stop_flag, .collision, .edge_count, .data_wr, .data_wdata,
    .shift_data_register, .timer_match, .clock_out_en, .data_out_en,
    .serial_clock_pin_i(scl_w), .serial_clock_pin_o, .serial_clock_pin_oe,
    .data_in_pin_i(sda_w), .data_in_pin_o, .data_in_pin_oe,
    .data_out_pin_o, .data_out_pin_oe, .start_wake, .rx_valid,
    .rx_ready, .rx_data
  );

  serial_far_end serial_far_end_i (
    .clk_seen(scl_w), .data_seen(sda_w), .miso(miso_w),
    .clk_drv(far_clk), .data_drv(far_dat)
  );

  // 40 MHz system clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Wait whole cycles, then step off the edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  // Control write; n above one repeats the strobes on adjacent edges
  task automatic ctrl(input logic [1:0] m, input logic cs, es, sc, tc,
                      input int n);
    @(posedge clk_sys);
    ctrl_wr                 <= 1'b1;
    wire_mode               <= m;
    clock_source_select_hi  <= cs;
    clock_edge_select       <= es;
    shift_clock_strobe      <= sc;
    clock_pin_toggle_strobe <= tc;
    repeat (n) @(posedge clk_sys);
    ctrl_wr                 <= 1'b0;
    shift_clock_strobe      <= 1'b0;
    clock_pin_toggle_strobe <= 1'b0;
  endtask : ctrl

  task automatic stat(input logic [7:0] v);
    @(posedge clk_sys);
    status_wr    <= 1'b1;
    status_wdata <= v;
    @(posedge clk_sys);
    status_wr    <= 1'b0;
  endtask : stat

  task automatic dwr(input logic [7:0] v);
    @(posedge clk_sys);
    data_wr    <= 1'b1;
    data_wdata <= v;
    @(posedge clk_sys);
    data_wr    <= 1'b0;
  endtask : dwr

  // Check the head word, then take it with a one-cycle ready
  task automatic pop(input logic [7:0] exp);
    `CHK(rx_valid, 1'b1)
    `CHK(rx_data, exp)
    @(posedge clk_sys) rx_ready <= 1'b1;
    @(posedge clk_sys) rx_ready <= 1'b0;
  endtask : pop

  task automatic t_reset();
    cyc(2);
    `CHK({start_detect_flag, counter_overflow_flag, rx_valid}, 3'h0)
    `CHK({edge_count, shift_data_register}, 12'h000)
    `CHK({serial_clock_pin_oe, data_out_pin_oe}, 2'h0)
  endtask : t_reset

  // Preload F, strobe into wrap; third wrap meets a full buffer
  task automatic t_soft();
    dwr(8'h81);
    stat(8'h0F);
    ctrl(2'b01, 1'b0, 1'b0, 1'b1, 1'b0, 1);
    cyc(2);
    `CHK(edge_count, 4'h0)
    `CHK(counter_overflow_flag, 1'b1)
    `CHK(shift_data_register, 8'h03)
    dwr(8'h40);
    stat(8'h4F);
    ctrl(2'b01, 1'b0, 1'b0, 1'b1, 1'b0, 1);
    stat(8'h4F);
    dwr(8'h00);
    ctrl(2'b01, 1'b0, 1'b0, 1'b1, 1'b0, 1);
    cyc(2);
    pop(8'h03);
    cyc(1);
    pop(8'h81);
    cyc(1);
    `CHK(rx_valid, 1'b0)
    ctrl(2'b01, 1'b0, 1'b1, 1'b0, 1'b0, 1);
    stat(8'h40);
    repeat (3) begin
      @(posedge clk_sys) timer_match <= 1'b1;
      @(posedge clk_sys) timer_match <= 1'b0;
    end
    cyc(2);
    `CHK(edge_count, 4'h3)
    stat(8'h40);
    ctrl(2'b01, 1'b1, 1'b0, 1'b1, 1'b1, 2);
    cyc(3);
    `CHK(edge_count, 4'h1)
  endtask : t_soft

  // Unit as three-wire master; clock level is low after one toggle
  task automatic t_spi_master();
    @(posedge clk_sys) clock_out_en <= 1'b1;
    data_out_en <= 1'b1;
    cyc(6);
    stat(8'h40);
    dwr(8'hA5);
    serial_far_end_i.tx_q = 8'h3C;
    serial_far_end_i.slave_en = 1'b1;
    repeat (16) begin
      ctrl(2'b01, 1'b1, 1'b0, 1'b1, 1'b1, 1);
      cyc(7);
    end
    `CHK(counter_overflow_flag, 1'b1)
    `CHK(edge_count, 4'h0)
    `CHK(shift_data_register, 8'h3C)
    `CHK(serial_far_end_i.rx_q, 8'hA5)
    pop(8'h3C);
    serial_far_end_i.slave_en = 1'b0;
  endtask : t_spi_master

  // Unit as three-wire slave, clock from the far side
  task automatic t_spi_slave();
    serial_far_end_i.mclk = 1'b0;
    @(posedge clk_sys) clock_out_en <= 1'b0;
    ctrl(2'b01, 1'b1, 1'b0, 1'b0, 1'b0, 1);
    stat(8'h40);
    dwr(8'h5A);
    cyc(4);
    serial_far_end_i.spi_xfer(8'hC3, got);
    cyc(8);
    `CHK(got, 8'h5A)
    `CHK(shift_data_register, 8'hC3)
    `CHK(edge_count, 4'h0)
    `CHK(counter_overflow_flag, 1'b1)
    pop(8'hC3);
  endtask : t_spi_slave

  // Start ignored in three-wire; then two-wire start, hold and address
  task automatic t_two_wire();
    serial_far_end_i.mclk = 1'b1;
    serial_far_end_i.mdata = 1'b1;
    ctrl(2'b01, 1'b0, 1'b0, 1'b0, 1'b1, 1);
    serial_far_end_i.mdata = 1'b0;
    cyc(12);
    `CHK(start_detect_flag, 1'b0)
    serial_far_end_i.mdata = 1'b1;
    ctrl(2'b11, 1'b1, 1'b0, 1'b0, 1'b0, 1);
    @(posedge clk_sys) clock_out_en <= 1'b1;
    data_out_en <= 1'b0;
    stat(8'hE0);
    dwr(8'hFF);
    cyc(4);
    serial_far_end_i.i2c_start();
    `CHK(start_detect_flag, 1'b1)
    `CHK(held, 1'b1)
    stat(8'h80);
    cyc(3);
    `CHK(start_detect_flag, 1'b0)
    `CHK(held, 1'b0)
    serial_far_end_i.i2c_byte(8'hA6);
    cyc(8);
    `CHK(counter_overflow_flag, 1'b1)
    `CHK(shift_data_register, 8'hA6)
    `CHK(held, 1'b1)
    pop(8'hA6);
    dwr(8'h00);
    @(posedge clk_sys) data_out_en <= 1'b1;
    stat(8'h4E);
    serial_far_end_i.i2c_ack(got[0]);
    cyc(8);
    `CHK(got[0], 1'b0)
    `CHK(edge_count, 4'h0)
    `CHK(held, 1'b1)
    pop(8'h00);
    stat(8'h40);
    cyc(3);
    `CHK(held, 1'b0)
    @(posedge clk_sys) data_out_en <= 1'b0;
    serial_far_end_i.i2c_stop();
    cyc(8);
    `CHK({stop_flag, collision}, 2'h3)
    serial_far_end_i.mdata = 1'b0;
    #1;
    `CHK(start_wake, 1'b1)
  endtask : t_two_wire

  task automatic summarize();
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_soft();
    t_spi_master();
    t_spi_slave();
    t_two_wire();
    summarize();
  end

  // Watchdog, well above the roughly 13 us the sequence needs
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
endmodule : universal_serial_shift_unit_tb
`default_nettype wire
